// ### logic/acrb_channel.sv
// Channel register bank with word FIFOs and label filter
`timescale 1ns/10ps

// ------------------------------------------------------------------
// Word FIFO
// ------------------------------------------------------------------
module acrb_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16,
   parameter int LEVEL = 8
) (
   input wire logic CLK_I, // Core clock
   input wire logic RESETN_I, // Async reset, active low
   input wire logic [WIDTH-1:0] in_data_i, // Word to store
   input wire logic in_valid_i, // Store request
   output logic in_ready_o, // Room available
   output logic [WIDTH-1:0] out_data_o, // Oldest word
   output logic out_valid_o, // Word available
   input wire logic out_ready_i, // Drain request
   output logic full_o, // No room left
   output logic level_o, // At or above level
   output logic empty_o // Nothing stored
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
   localparam logic [AW:0] LEVEL_C = (AW+1)'(LEVEL);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] cnt;
      logic full;
      logic level;
      logic empty;
      logic valid;
      logic [WIDTH-1:0] head;
   } acrb_fifo_state_t;
   acrb_fifo_state_t q, d;
   logic push;
   logic pop;

   always_comb begin
      d = q;
      push = in_valid_i && !q.full;
      pop = out_ready_i && !q.empty;
      if (push) begin
         d.mem[q.wr] = in_data_i;
         d.wr = AW'(q.wr + 1'b1);
      end
      if (pop) begin
         d.rd = AW'(q.rd + 1'b1);
      end
      if (push && !pop) begin
         d.cnt = (AW+1)'(q.cnt + 1'b1);
      end else if (pop && !push) begin
         d.cnt = (AW+1)'(q.cnt - 1'b1);
      end
      d.full = (d.cnt == DEPTH_C);
      d.level = (d.cnt >= LEVEL_C);
      d.empty = (d.cnt == '0);
      d.valid = !d.empty;
      d.head = d.mem[d.rd];
   end
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         q <= '0;
         q.empty <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign in_ready_o = !q.full;
   assign out_valid_o = q.valid;
   assign out_data_o = q.head;
   assign full_o = q.full;
   assign level_o = q.level;
   assign empty_o = q.empty;
endmodule // acrb_fifo

// ------------------------------------------------------------------
// Channel register bank
// ------------------------------------------------------------------
module acrb_channel (
   input wire logic CLK_I, // Core clock, 100 MHz
   input wire logic RESETN_I, // Async reset, active low
   input wire acrb_pkg::acrb_cpu_req_t CPU_REQ_I, // Host strobes, addr, data
   output logic [31:0] CPU_DOUT_O, // Host read data
   output logic CPU_WAIT_O, // Host hold request
   input wire logic [31:0] RX_WORD_I, // Word from serial receiver
   input wire logic RX_VALID_I, // Receiver word valid
   output logic RX_READY_O, // Bank can take a word
   output logic [31:0] TX_WORD_O, // Word to serial transmitter
   output logic TX_VALID_O, // Transmit word valid
   input wire logic TX_READY_I, // Transmitter takes word
   output logic [7:0] RX_CFG_O, // Receive configuration
   output logic [3:0] TX_CFG_O // Transmit configuration
);
   localparam int LD = acrb_pkg::LABEL_DEPTH;
   localparam int PW = acrb_pkg::LABEL_PTR_W;
   typedef struct packed {
      logic [7:0] rx_cfg;
      logic [3:0] tx_cfg;
      logic [31:0] rx_word;
      logic [LD-1:0][7:0] labels;
      logic [LD-1:0] lab_valid;
      logic [PW-1:0] wr_ptr;
      logic [PW-1:0] rd_ptr;
      logic ren_n_prev;
      logic wen_n_prev;
      logic [31:0] dout;
      logic wait_out;
      acrb_pkg::acrb_flags_t rx_flags;
      acrb_pkg::acrb_flags_t tx_flags;
      logic [31:0] stage;
      logic stage_full;
      logic rx_ready;
   } acrb_top_state_t;
   acrb_top_state_t q, d;
   logic rd_start;
   logic wr_start;
   logic hit;
   logic is_tx;
   logic [1:0] idx;
   logic [LD-1:0] lab_hit;
   logic lab_match;
   logic sdi_ok;
   logic par_ok;
   logic pass;
   logic rx_push;
   logic rx_pop;
   logic tx_push;
   logic rx_in_ready;
   logic [31:0] rx_head;
   logic rx_head_valid;
   acrb_pkg::acrb_flags_t rx_fifo_flags;
   acrb_pkg::acrb_flags_t tx_fifo_flags;
   logic tx_in_ready;

   // ---------------------------------------------------------------
   // Label compare, one comparator per table entry
   // ---------------------------------------------------------------
   for (genvar i = 0; i < LD; i++) begin : g_match
      // Stale entries from before a reload never match
      assign lab_hit[i] = q.lab_valid[i] &&
         (q.labels[i] == q.stage[acrb_pkg::WORD_LABEL_MSB:0]);
   end
   assign lab_match = |lab_hit;
   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      d = q;
      rx_push = 1'b0;
      rx_pop = 1'b0;
      tx_push = 1'b0;
      // Strobes may be held for several cycles; act once per access
      rd_start = !CPU_REQ_I.ren_n && q.ren_n_prev;
      wr_start = !CPU_REQ_I.wen_n && q.wen_n_prev;
      hit = (CPU_REQ_I.addr[acrb_pkg::ADDR_CHAN_LSB +: 4] ==
         acrb_pkg::CHANNEL_NUM) &&
         (CPU_REQ_I.addr[acrb_pkg::ADDR_BYTE_LSB +: 2] ==
         acrb_pkg::BYTE_IDX_WORD);
      is_tx = CPU_REQ_I.addr[acrb_pkg::ADDR_DIR_BIT];
      idx = CPU_REQ_I.addr[acrb_pkg::ADDR_IDX_LSB +: 2];
      d.ren_n_prev = CPU_REQ_I.ren_n;
      d.wen_n_prev = CPU_REQ_I.wen_n;
      d.wait_out = 1'b0;
      // Incoming word checks
      sdi_ok = !q.rx_cfg[acrb_pkg::RX_CFG_SDI_EN] ||
         ((q.stage[acrb_pkg::WORD_SDI9] ==
         q.rx_cfg[acrb_pkg::RX_CFG_SDI9]) &&
         (q.stage[acrb_pkg::WORD_SDI10] ==
         q.rx_cfg[acrb_pkg::RX_CFG_SDI10]));
      par_ok = !q.rx_cfg[acrb_pkg::CFG_PAR_EN] ||
         ((^q.stage) != q.rx_cfg[acrb_pkg::CFG_PAR_EVEN]);
      pass = sdi_ok && par_ok &&
         (!q.rx_cfg[acrb_pkg::RX_CFG_FILTER] || lab_match);
      // Stage drains into the FIFO or is dropped; full FIFO stalls it
      if (q.stage_full) begin
         if (!pass) begin
            d.stage_full = 1'b0;
         end else if (rx_in_ready) begin
            rx_push = 1'b1;
            d.stage_full = 1'b0;
         end
      end
      if (q.rx_ready && RX_VALID_I) begin
         d.stage = RX_WORD_I;
         d.stage_full = 1'b1;
      end
      d.rx_ready = !d.stage_full;
      d.rx_flags = rx_fifo_flags;
      d.tx_flags = tx_fifo_flags;
      // Host write; writes win over a simultaneous read start
      if (wr_start && hit) begin
         if (!is_tx) begin
            case (idx)
               acrb_pkg::IDX_CFG: begin
                  d.rx_cfg = CPU_REQ_I.din[7:0];
                  if (CPU_REQ_I.din[acrb_pkg::RX_CFG_RELOAD]) begin
                     d.wr_ptr = '0;
                     d.rd_ptr = '0;
                     d.lab_valid = '0;
                  end
               end
               acrb_pkg::IDX_LABEL: begin
                  d.labels[q.wr_ptr] = CPU_REQ_I.din[7:0];
                  d.lab_valid[q.wr_ptr] = 1'b1;
                  d.wr_ptr = PW'(q.wr_ptr + 1'b1);
               end
               default: begin
                  // Word and flags are read-only
               end
            endcase
         end else begin
            case (idx)
               acrb_pkg::IDX_WORD: begin
                  // Word is lost if FIFO full; host watches full flag
                  tx_push = tx_in_ready;
               end
               acrb_pkg::IDX_CFG:
                  d.tx_cfg = CPU_REQ_I.din[3:0];
               default: begin
                  // Flags read-only, index 11 unmapped
               end
            endcase
         end
      end else if (rd_start) begin
         d.dout = '0;
         if (hit && !is_tx) begin
            case (idx)
               acrb_pkg::IDX_WORD: begin
                  if (rx_head_valid) begin
                     d.rx_word = rx_head;
                     rx_pop = 1'b1;
                  end
                  d.dout = d.rx_word;
               end
               acrb_pkg::IDX_CFG: d.dout = {24'h000000, q.rx_cfg};
               acrb_pkg::IDX_FLAGS:
                  d.dout = {29'h00000000, q.rx_flags};
               acrb_pkg::IDX_LABEL: begin
                  d.dout = {24'h000000, q.labels[q.rd_ptr]};
                  d.rd_ptr = PW'(q.rd_ptr + 1'b1);
               end
               default: d.dout = '0;
            endcase
         end else if (hit) begin
            case (idx)
               acrb_pkg::IDX_CFG: d.dout = {28'h0000000, q.tx_cfg};
               acrb_pkg::IDX_FLAGS:
                  d.dout = {29'h00000000, q.tx_flags};
               default: d.dout = '0;
            endcase
         end
      end
   end

   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // ---------------------------------------------------------------
   // Receive and transmit FIFOs
   // ---------------------------------------------------------------
   acrb_fifo #(
      .WIDTH(32),
      .DEPTH(acrb_pkg::FIFO_DEPTH),
      .LEVEL(acrb_pkg::FIFO_LEVEL)
   ) u_rx_fifo (
      .CLK_I(CLK_I),
      .RESETN_I(RESETN_I),
      .in_data_i(q.stage),
      .in_valid_i(rx_push),
      .in_ready_o(rx_in_ready),
      .out_data_o(rx_head),
      .out_valid_o(rx_head_valid),
      .out_ready_i(rx_pop),
      .full_o(rx_fifo_flags.full),
      .level_o(rx_fifo_flags.level),
      .empty_o(rx_fifo_flags.empty)
   );

   acrb_fifo #(
      .WIDTH(32),
      .DEPTH(acrb_pkg::FIFO_DEPTH),
      .LEVEL(acrb_pkg::FIFO_LEVEL)
   ) u_tx_fifo (
      .CLK_I(CLK_I),
      .RESETN_I(RESETN_I),
      .in_data_i(CPU_REQ_I.din),
      .in_valid_i(tx_push),
      .in_ready_o(tx_in_ready),
      .out_data_o(TX_WORD_O),
      .out_valid_o(TX_VALID_O),
      .out_ready_i(TX_READY_I),
      .full_o(tx_fifo_flags.full),
      .level_o(tx_fifo_flags.level),
      .empty_o(tx_fifo_flags.empty)
   );

   assign CPU_DOUT_O = q.dout;
   assign CPU_WAIT_O = q.wait_out;
   assign RX_READY_O = q.rx_ready;
   assign RX_CFG_O = q.rx_cfg;
   assign TX_CFG_O = q.tx_cfg;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   rx_cfg_write_a: assert property (
      @(posedge CLK_I) disable iff (!RESETN_I)
      (wr_start && hit && !is_tx && idx == acrb_pkg::IDX_CFG)
      |=> (RX_CFG_O == $past(CPU_REQ_I.din[7:0])))
      else $error("rx config write not stored");
   reload_ptrs_a: assert property (
      @(posedge CLK_I) disable iff (!RESETN_I)
      (wr_start && hit && !is_tx && idx == acrb_pkg::IDX_CFG &&
      CPU_REQ_I.din[acrb_pkg::RX_CFG_RELOAD])
      |=> (q.wr_ptr == '0 && q.rd_ptr == '0 && q.lab_valid == '0))
      else $error("reload did not clear label pointers");
   label_wr_step_a: assert property (
      @(posedge CLK_I) disable iff (!RESETN_I)
      (wr_start && hit && !is_tx && idx == acrb_pkg::IDX_LABEL)
      |=> (q.wr_ptr == PW'($past(q.wr_ptr) + 1'b1)) &&
      q.lab_valid[$past(q.wr_ptr)])
      else $error("label write pointer did not advance");
   label_rd_step_a: assert property (
      @(posedge CLK_I) disable iff (!RESETN_I)
      (rd_start && !wr_start && hit && !is_tx &&
      idx == acrb_pkg::IDX_LABEL)
      |=> (q.rd_ptr == PW'($past(q.rd_ptr) + 1'b1)) &&
      (CPU_DOUT_O[7:0] == $past(q.labels[q.rd_ptr])))
      else $error("label read pointer or data wrong");
   tx_unused_a: assert property (
      @(posedge CLK_I) disable iff (!RESETN_I)
      (rd_start && !wr_start && hit && is_tx &&
      idx == acrb_pkg::IDX_LABEL) |=> (CPU_DOUT_O == '0))
      else $error("unused tx index read nonzero");
   flags_read_a: assert property (
      @(posedge CLK_I) disable iff (!RESETN_I)
      (rd_start && !wr_start && hit && !is_tx &&
      idx == acrb_pkg::IDX_FLAGS)
      |=> (CPU_DOUT_O == {29'h00000000, $past(q.rx_flags)}))
      else $error("rx flags read wrong");
   tx_push_a: assert property (
      @(posedge CLK_I) disable iff (!RESETN_I)
      (wr_start && hit && is_tx && idx == acrb_pkg::IDX_WORD &&
      tx_in_ready) |=> ##[0:1] TX_VALID_O)
      else $error("tx word write not queued");
   sdi_reject_a: assert property (
      @(posedge CLK_I) disable iff (!RESETN_I)
      (q.stage_full && q.rx_cfg[acrb_pkg::RX_CFG_SDI_EN] &&
      (q.stage[acrb_pkg::WORD_SDI9] != q.rx_cfg[acrb_pkg::RX_CFG_SDI9]))
      |-> !rx_push ##1 !q.stage_full)
      else $error("word with wrong SDI accepted");
   filter_reject_a: assert property (
      @(posedge CLK_I) disable iff (!RESETN_I)
      (q.stage_full && q.rx_cfg[acrb_pkg::RX_CFG_FILTER] && !lab_match)
      |-> !rx_push)
      else $error("unlisted label accepted");
endmodule // acrb_channel

// ### logic/acrb_pkg.sv
// Constants, types and field layout of the channel register bank
package acrb_pkg;
   // ---------------------------------------------------------------
   // Address layout
   // ---------------------------------------------------------------
   localparam int ADDR_W = 9;
   localparam int DATA_W = 32;
   localparam int ADDR_BYTE_LSB = 0;
   localparam int ADDR_IDX_LSB = 2;
   localparam int ADDR_DIR_BIT = 4;
   localparam int ADDR_CHAN_LSB = 5;
   localparam logic [1:0] BYTE_IDX_WORD = 2'h0;
   localparam logic [3:0] CHANNEL_NUM = 4'h0;
   localparam logic [1:0] IDX_WORD = 2'h0;
   localparam logic [1:0] IDX_CFG = 2'h1;
   localparam logic [1:0] IDX_FLAGS = 2'h2;
   localparam logic [1:0] IDX_LABEL = 2'h3;
   // ---------------------------------------------------------------
   // Configuration fields
   // ---------------------------------------------------------------
   localparam int CFG_RATE = 0;
   localparam int RX_CFG_FILTER = 1;
   localparam int TX_CFG_LOOP = 1;
   localparam int CFG_PAR_EN = 2;
   localparam int CFG_PAR_EVEN = 3;
   localparam int RX_CFG_SDI_EN = 4;
   localparam int RX_CFG_SDI9 = 5;
   localparam int RX_CFG_SDI10 = 6;
   localparam int RX_CFG_RELOAD = 7;
   localparam logic [7:0] RX_CFG_RST = 8'h00;
   localparam logic [3:0] TX_CFG_RST = 4'h0;
   // ---------------------------------------------------------------
   // Word fields and storage sizes
   // ---------------------------------------------------------------
   localparam int WORD_LABEL_MSB = 7;
   localparam int WORD_SDI9 = 8;
   localparam int WORD_SDI10 = 9;
   localparam int LABEL_DEPTH = 8;
   localparam int LABEL_PTR_W = 3;
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_LEVEL = 8;
   localparam int FLAG_EMPTY = 0;
   localparam int FLAG_LEVEL = 1;
   localparam int FLAG_FULL = 2;
   // ---------------------------------------------------------------
   // Carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic ren_n;
      logic wen_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] din;
   } acrb_cpu_req_t;
   typedef struct packed {
      logic full;
      logic level;
      logic empty;
   } acrb_flags_t;
endpackage

// ### verification/acrb_host.sv
// Host CPU model for the channel register port
`timescale 1ns/10ps
module acrb_host (
   input wire logic clk_i, // Core clock
   input wire logic [31:0] dout_i, // Read data from the bank
   output acrb_pkg::acrb_cpu_req_t req_o // Strobes, address, data
);
   initial req_o = {2'h3, 9'h000, 32'h0};
   // ------------------------------------------------------------
   // One access, entered just after a rising edge
   // ------------------------------------------------------------
   task automatic acc(input logic we, input logic [8:0] a,
         input logic [31:0] d, output logic [31:0] q);
      req_o.addr = a;
      req_o.din = d;
      req_o.wen_n = ~we;
      req_o.ren_n = we;
      @(posedge clk_i);
      #1;
      // Released lines carry junk so stale values cannot pass
      req_o = {2'h3, ~a, ~d};
      // Strobe seen high for one edge before the next access
      @(posedge clk_i);
      #1;
      q = dout_i;
   endtask
endmodule // acrb_host

// ### verification/tb.sv
// Self-checking bench for the channel register bank
`timescale 1ns/10ps
module tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   acrb_pkg::acrb_cpu_req_t req;
   logic [31:0] dout;
   logic wait_s;
   logic [31:0] rx_word = 32'h0;
   logic rx_valid = 1'b0;
   logic rx_ready;
   logic [31:0] tx_word;
   logic tx_valid;
   logic tx_ready = 1'b0;
   logic tx_go = 1'b0;
   logic [7:0] rx_cfg;
   logic [3:0] tx_cfg;
   int failures = 0;
   int num_checks = 0;
   logic [31:0] seed = 32'h56;
   logic [31:0] rd, w, d;
   logic [7:0] c;
   logic [7:0] labels[$], old[$];
   logic [31:0] exp_q[$], tx_seen[$];
   logic [7:0] cfgs[9] = '{8'h02, 8'h03, 8'h04, 8'h0C, 8'h16, 8'h30,
      8'h5A, 8'h72, 8'h63};

   always #5 clk = ~clk;

   acrb_channel uut (
      .CLK_I(clk),
      .RESETN_I(rst_n),
      .CPU_REQ_I(req),
      .CPU_DOUT_O(dout),
      .CPU_WAIT_O(wait_s),
      .RX_WORD_I(rx_word),
      .RX_VALID_I(rx_valid),
      .RX_READY_O(rx_ready),
      .TX_WORD_O(tx_word),
      .TX_VALID_O(tx_valid),
      .TX_READY_I(tx_ready),
      .RX_CFG_O(rx_cfg),
      .TX_CFG_O(tx_cfg)
   );
   acrb_host host (.clk_i(clk), .dout_i(dout), .req_o(req));

   // ------------------------------------------------------------
   // Transmitter side: random stalls while enabled
   // ------------------------------------------------------------
   always @(posedge clk) begin
      #1;
      tx_ready = tx_go && (rnd() % 3 != 0);
   end
   always @(posedge clk)
      if (tx_valid === 1'b1 && tx_ready === 1'b1)
         tx_seen.push_back(tx_word);

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic [8:0] ad(logic tx, logic [1:0] idx);
      return {acrb_pkg::CHANNEL_NUM, tx, idx, acrb_pkg::BYTE_IDX_WORD};
   endfunction

   // Whether a received word should reach the FIFO
   function automatic bit accepts(logic [31:0] x, logic [7:0] k);
      bit hit = (k[1] == 1'b0);
      foreach (labels[i])
         if (labels[i] == x[7:0])
            hit = 1'b1;
      if (k[4] && x[9:8] != k[6:5])
         return 1'b0;
      if (k[2] && (^x) == k[3])
         return 1'b0;
      return hit;
   endfunction

   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic test_done();
      $display("checks %0d, failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic note(string s);
      $display("test %s finished", s);
   endtask

   task automatic idle(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wr(logic [8:0] a, logic [31:0] v);
      host.acc(1'b1, a, v, rd);
   endtask

   task automatic rdc(string what, logic [8:0] a, logic [31:0] exp);
      host.acc(1'b0, a, 32'h0, rd);
      chk(what, exp, rd);
      chk("cpu wait", 32'h0, {31'h0, wait_s});
   endtask

   // Receiver side: hold the word until the bank takes it
   task automatic send(logic [31:0] x);
      rx_word = x;
      rx_valid = 1'b1;
      for (int n = 0; rx_ready !== 1'b1; n++) begin
         if (n == 40) begin
            failures++;
            test_done();
         end
         idle(1);
      end
      idle(1);
      rx_valid = 1'b0;
      rx_word = ~x;
      // Valid stays low across one edge before the next word
      idle(1);
   endtask

   // Reload, write n labels, read them back
   task automatic prog(int n);
      old = labels;
      labels = {};
      wr(ad(1'b0, 2'h1), 32'h80);
      for (int i = 0; i < n; i++) begin
         labels.push_back(8'(rnd()));
         wr(ad(1'b0, 2'h3), {24'h0, labels[i]});
      end
      for (int i = 0; i < n; i++)
         rdc("label", ad(1'b0, 2'h3), {24'h0, labels[i]});
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (2) @(posedge clk);
      #1;
      rst_n = 1'b1;
      // Flags follow the FIFOs from the first edge after reset
      idle(2);
      for (int i = 0; i < 8; i++)
         rdc("reset", ad(i[2], i[1:0]), {31'h0, i[1:0] == 2'h2});
      note("reset values");
      for (int i = 0; i < 4; i++) begin
         d = rnd();
         wr(ad(1'b1, 2'h1), d);
         rdc("tx cfg", ad(1'b1, 2'h1), {28'h0, d[3:0]});
         chk("tx cfg out", {28'h0, d[3:0]}, {28'h0, tx_cfg});
      end
      wr(ad(1'b0, 2'h2), 32'hFFFF_FFFF);
      wr(ad(1'b1, 2'h2), 32'hFFFF_FFFF);
      wr(ad(1'b1, 2'h3), 32'hFFFF_FFFF);
      rdc("rx flags", ad(1'b0, 2'h2), 32'h1);
      rdc("tx flags", ad(1'b1, 2'h2), 32'h1);
      rdc("tx unused", ad(1'b1, 2'h3), 32'h0);
      wr(9'h024, 32'h0000_00FF);
      wr(9'h005, 32'h0000_00FF);
      rdc("rx cfg", ad(1'b0, 2'h1), 32'h0);
      rdc("other channel", 9'h024, 32'h0);
      rdc("byte index", 9'h005, 32'h0);
      note("register map");
      prog(3);
      prog(4);
      for (int k = 0; k < 9; k++) begin
         // Reload in mid-run: old labels must stop matching
         if (k == 5)
            prog(3);
         c = cfgs[k];
         d = rnd();
         d[7:0] = c;
         wr(ad(1'b0, 2'h1), d);
         rdc("rx cfg", ad(1'b0, 2'h1), {24'h0, c});
         chk("rx cfg out", {24'h0, c}, {24'h0, rx_cfg});
         for (int j = 0; j < 6; j++) begin
            w = rnd();
            if (j % 3 == 1)
               w[7:0] = labels[rnd() % labels.size()];
            if (j % 3 == 2)
               w[7:0] = old[rnd() % old.size()];
            if (accepts(w, c))
               exp_q.push_back(w);
            send(w);
         end
         idle(4);
         while (exp_q.size() > 0)
            rdc("rx word", ad(1'b0, 2'h0), exp_q.pop_front());
         idle(2);
         rdc("rx flags", ad(1'b0, 2'h2), 32'h1);
      end
      note("receive filter");
      wr(ad(1'b0, 2'h1), 32'h0);
      for (int i = 0; i < 17; i++) begin
         exp_q.push_back(rnd());
         send(exp_q[i]);
      end
      idle(4);
      chk("rx ready", 32'h0, {31'h0, rx_ready});
      rdc("rx flags", ad(1'b0, 2'h2), 32'h6);
      while (exp_q.size() > 0)
         rdc("rx word", ad(1'b0, 2'h0), exp_q.pop_front());
      idle(2);
      rdc("rx flags", ad(1'b0, 2'h2), 32'h1);
      note("receive fifo");
      for (int i = 0; i < 17; i++) begin
         w = rnd();
         if (i < 16)
            exp_q.push_back(w);
         wr(ad(1'b1, 2'h0), w);
      end
      idle(2);
      rdc("tx flags", ad(1'b1, 2'h2), 32'h6);
      rdc("tx word read", ad(1'b1, 2'h0), 32'h0);
      tx_go = 1'b1;
      for (int n = 0; tx_seen.size() < 16; n++) begin
         if (n == 500) begin
            failures++;
            test_done();
         end
         idle(1);
      end
      idle(4);
      tx_go = 1'b0;
      chk("tx count", 32'd16, tx_seen.size());
      while (exp_q.size() > 0 && tx_seen.size() > 0)
         chk("tx word", exp_q.pop_front(), tx_seen.pop_front());
      rdc("tx flags", ad(1'b1, 2'h2), 32'h1);
      note("transmit fifo");
      test_done();
   end
endmodule // tb
